/* core/csg_clock_ctrl.sv */
// Purpose: Clock source selection, clock gates and oscillator key for the front end
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses, one clock
// Notes: Ack comes one cycle after the request is seen, for one cycle
//
// Operation
// - The converter clock source follows selector bits 3:2, 0 fast osc, 1 crystal, 2 slow, 3 ext.
// - The system clock source follows selector bits 1:0 with the same coding, both reset to 0.
// - Chop bit 2 at 1 stops the amplifier chop clock, at 0 runs it, resetting to 1.
// - Chop bit 1 at 1 stops the wake timer clock, at 0 runs it, resetting to 0.
// - Gate bit 5 at 1 stops the front-end control clock, at 0 (reset) runs it.
// - Oscillator control writes are ignored unless the key 0xcb14 was written just before.
// - Any write to another register after the key re-locks the oscillator control.
// - Oscillator control holds crystal, fast and slow enables at bits 2:0, resetting to 3.
//
// The Wishbone slave port is this design's own decision.
`include "csg_params.svh"

module csg_clock_ctrl #(
  parameter int SWITCH_HOLD = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`CSG_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Clock source selection
  output csg_pkg::csg_src_e converter_clock_source_o,
  output csg_pkg::csg_src_e system_clock_source_o,
  output logic [3:0] converter_clock_en_o,
  output logic [3:0] system_clock_en_o,
  // Clock gates
  output logic chop_clock_off_o,
  output logic wake_timer_clock_off_o,
  output logic frontend_control_clock_off_o,
  output logic [15:0] clock_gate_enables_o,
  // Oscillator enables
  output logic [2:0] oscillator_control_o
);
  import csg_pkg::*;

  logic [15:0] clock_source_select_reg;
  logic [15:0] chop_and_wake_timer_gates_reg;
  logic [15:0] clock_gate_enables_reg;
  logic [15:0] oscillator_unlock_key_reg;
  logic [15:0] oscillator_control_reg;
  logic unlocked_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [3:0] conv_en_reg;
  logic [3:0] sys_en_reg;
  csg_src_e conv_src_reg;
  csg_src_e sys_src_reg;
  logic [2:0] osc_out_reg;
  logic chop_off_reg;
  logic wake_off_reg;
  logic fe_off_reg;

  wire logic req;
  wire logic wr;
  wire logic hit_sel;
  wire logic hit_chop;
  wire logic hit_gates;
  wire logic hit_key;
  wire logic hit_osc;
  wire logic [15:0] lane_mask;
  wire logic [15:0] wdata;
  wire logic key_match;
  wire logic osc_wr_ok;
  wire logic [15:0] rdata;
  wire csg_src_e conv_req;
  wire csg_src_e sys_req;
  wire csg_src_e conv_sel;
  wire csg_src_e sys_sel;
  wire logic [3:0] conv_en;
  wire logic [3:0] sys_en;

  // Request taken only while ack is low, so each access acts exactly once
  assign req = cyc_i && stb_i && !ack_reg;
  assign wr = req && we_i;
  assign hit_sel = (adr_i == `CSG_OFF_SEL);
  assign hit_chop = (adr_i == `CSG_OFF_CHOP);
  assign hit_gates = (adr_i == `CSG_OFF_GATES);
  assign hit_key = (adr_i == `CSG_OFF_KEY);
  assign hit_osc = (adr_i == `CSG_OFF_OSC);
  assign lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wdata = dat_i[15:0];
  assign key_match = (wdata == `CSG_UNLOCK_KEY) && (sel_i[1:0] == 2'b11);
  assign osc_wr_ok = wr && hit_osc && unlocked_reg;

  assign rdata = hit_sel ? clock_source_select_reg :
                 hit_chop ? chop_and_wake_timer_gates_reg :
                 hit_gates ? clock_gate_enables_reg :
                 hit_key ? oscillator_unlock_key_reg :
                 hit_osc ? oscillator_control_reg :
                 16'h0000;

  assign conv_req = csg_src_e'(clock_source_select_reg[`CSG_ADC_SEL_HI:`CSG_ADC_SEL_LO]);
  assign sys_req = csg_src_e'(clock_source_select_reg[`CSG_SYS_SEL_HI:`CSG_SYS_SEL_LO]);

  // Register writes; reserved bits are masked so they keep reading zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_source_select_reg <= `CSG_RST_SEL;
      chop_and_wake_timer_gates_reg <= `CSG_RST_CHOP;
      clock_gate_enables_reg <= `CSG_RST_GATES;
      oscillator_unlock_key_reg <= `CSG_RST_KEY;
      oscillator_control_reg <= `CSG_RST_OSC;
    end else begin
      // Slow oscillator coding stored as written; no hardware refusal
      if (wr && hit_sel) begin
        clock_source_select_reg <= (clock_source_select_reg & ~lane_mask) |
                                   (wdata & lane_mask & `CSG_SEL_MASK);
      end
      if (wr && hit_chop) begin
        chop_and_wake_timer_gates_reg <= (chop_and_wake_timer_gates_reg & ~lane_mask) |
                                         (wdata & lane_mask & `CSG_CHOP_MASK);
      end
      // Bits outside the documented fields are software's to keep intact
      if (wr && hit_gates) begin
        clock_gate_enables_reg <= (clock_gate_enables_reg & ~lane_mask) |
                                  (wdata & lane_mask & `CSG_GATES_MASK);
      end
      if (wr && hit_key) begin
        oscillator_unlock_key_reg <= (oscillator_unlock_key_reg & ~lane_mask) |
                                     (wdata & lane_mask);
      end
      if (osc_wr_ok) begin
        oscillator_control_reg <= (oscillator_control_reg & ~lane_mask) |
                                  (wdata & lane_mask & `CSG_OSC_MASK);
      end
    end
  end

  // Unlock lasts until the next write of any kind; reads leave it alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlocked_reg <= 1'b0;
    end else if (wr) begin
      unlocked_reg <= hit_key && key_match;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      dat_reg <= (req && !we_i) ? {16'h0000, rdata} : 32'h0000_0000;
    end
  end

  csg_clk_switch #(
    .HOLD_CYCLES(SWITCH_HOLD)
  ) u_conv_switch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(conv_req),
    .sel_o(conv_sel),
    .en_o(conv_en),
    .busy_o()
  );

  csg_clk_switch #(
    .HOLD_CYCLES(SWITCH_HOLD)
  ) u_sys_switch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(sys_req),
    .sel_o(sys_sel),
    .en_o(sys_en),
    .busy_o()
  );

  // Output flops keep every top-level output straight from a register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_src_reg <= CSG_SRC_HFOSC;
      sys_src_reg <= CSG_SRC_HFOSC;
      conv_en_reg <= 4'h1;
      sys_en_reg <= 4'h1;
      chop_off_reg <= 1'b1;
      wake_off_reg <= 1'b0;
      fe_off_reg <= 1'b0;
      osc_out_reg <= 3'(`CSG_RST_OSC);
    end else begin
      conv_src_reg <= conv_sel;
      sys_src_reg <= sys_sel;
      conv_en_reg <= conv_en;
      sys_en_reg <= sys_en;
      chop_off_reg <= chop_and_wake_timer_gates_reg[`CSG_CHOP_OFF_BIT];
      wake_off_reg <= chop_and_wake_timer_gates_reg[`CSG_WAKE_OFF_BIT];
      fe_off_reg <= clock_gate_enables_reg[`CSG_FE_OFF_BIT];
      osc_out_reg <= oscillator_control_reg[2:0];
    end
  end

  assign dat_o = dat_reg;
  assign ack_o = ack_reg;
  assign converter_clock_source_o = conv_src_reg;
  assign system_clock_source_o = sys_src_reg;
  assign converter_clock_en_o = conv_en_reg;
  assign system_clock_en_o = sys_en_reg;
  assign chop_clock_off_o = chop_off_reg;
  assign wake_timer_clock_off_o = wake_off_reg;
  assign frontend_control_clock_off_o = fe_off_reg;
  assign clock_gate_enables_o = clock_gate_enables_reg;
  assign oscillator_control_o = osc_out_reg;
endmodule : csg_clock_ctrl

/* core/csg_params.svh */
// Purpose: Offsets, field positions, reset values and key for the clock control block
// Assumes: Wishbone byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef CSG_PARAMS_SVH
`define CSG_PARAMS_SVH

`define CSG_ADDR_W 12
`define CSG_OFF_GATES 12'h410
`define CSG_OFF_SEL 12'h414
`define CSG_OFF_KEY 12'ha0c
`define CSG_OFF_OSC 12'ha10
`define CSG_OFF_CHOP 12'ha70

`define CSG_RST_GATES 16'h01c0
`define CSG_RST_SEL 16'h0000
`define CSG_RST_KEY 16'h0000
`define CSG_RST_OSC 16'h0003
`define CSG_RST_CHOP 16'h0004

`define CSG_GATES_MASK 16'h03ff
`define CSG_SEL_MASK 16'h000f
`define CSG_OSC_MASK 16'h0007
`define CSG_CHOP_MASK 16'h0007

`define CSG_UNLOCK_KEY 16'hcb14

`define CSG_ADC_SEL_HI 3
`define CSG_ADC_SEL_LO 2
`define CSG_SYS_SEL_HI 1
`define CSG_SYS_SEL_LO 0
`define CSG_CHOP_OFF_BIT 2
`define CSG_WAKE_OFF_BIT 1
`define CSG_FE_OFF_BIT 5
`define CSG_XTAL_EN_BIT 2
`define CSG_HFOSC_EN_BIT 1
`define CSG_LFOSC_EN_BIT 0

`endif

/* core/csg_pkg.sv */
// Purpose: Types shared by the clock control block
// Assumes: Nothing
// Notes: Source encoding is common to both selectors
package csg_pkg;
  typedef enum logic [1:0] {
    CSG_SRC_HFOSC = 2'b00,
    CSG_SRC_XTAL = 2'b01,
    CSG_SRC_LFOSC = 2'b10,
    CSG_SRC_EXT = 2'b11
  } csg_src_e;

  typedef enum logic [1:0] {
    CSG_SW_RUN = 2'b00,
    CSG_SW_WAIT = 2'b01,
    CSG_SW_HOLD = 2'b10
  } csg_sw_state_e;
endpackage : csg_pkg

/* core/csg_clk_switch.sv */
// Purpose: Glitch-free switch of one clock selector
// Assumes: Runs on the system clock; clock enable outputs gate real clocks downstream
// Notes: Enables are parked low for a wait period, then the new source is selected and held a second period before it is enabled
module csg_clk_switch #(
  parameter int HOLD_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requested source
  input csg_pkg::csg_src_e req_i,
  // Applied source and one-hot enables
  output csg_pkg::csg_src_e sel_o,
  output logic [3:0] en_o,
  output logic busy_o
);
  import csg_pkg::*;

  localparam int CW = $clog2(HOLD_CYCLES + 1);

  csg_sw_state_e state_reg;
  csg_sw_state_e state_next;
  csg_src_e sel_reg;
  csg_src_e sel_next;
  logic [3:0] en_reg;
  logic [3:0] en_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  wire logic cnt_done;

  assign cnt_done = (cnt_reg == CW'(HOLD_CYCLES));

  // Break before make: no output ever sees two sources or a cut pulse
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    en_next = en_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      CSG_SW_RUN: begin
        if (req_i != sel_reg) begin
          en_next = 4'h0;
          cnt_next = '0;
          state_next = CSG_SW_WAIT;
        end
      end
      CSG_SW_WAIT: begin
        cnt_next = cnt_reg + CW'(1);
        if (cnt_done) begin
          sel_next = req_i;
          cnt_next = '0;
          state_next = CSG_SW_HOLD;
        end
      end
      CSG_SW_HOLD: begin
        cnt_next = cnt_reg + CW'(1);
        if (cnt_done) begin
          en_next = 4'h1 << sel_reg;
          state_next = CSG_SW_RUN;
        end
      end
      default: begin
        state_next = CSG_SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= CSG_SW_RUN;
      sel_reg <= CSG_SRC_HFOSC;
      en_reg <= 4'h1;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      en_reg <= en_next;
      cnt_reg <= cnt_next;
    end
  end

  assign sel_o = sel_reg;
  assign en_o = en_reg;
  assign busy_o = (state_reg != CSG_SW_RUN);
endmodule : csg_clk_switch

/* verification/csg_clock_ctrl_sva.sv */
// Purpose: Port-level checks for csg_clock_ctrl
// Assumes: Writes taken when cyc and stb are high while ack is low
// Notes: Lock state is tracked here, since the design keeps it hidden
module csg_clock_ctrl_sva #(
  parameter int SWITCH_HOLD = 4
) (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Clock controls
  input wire csg_pkg::csg_src_e converter_clock_source_o,
  input wire csg_pkg::csg_src_e system_clock_source_o,
  input wire logic [3:0] converter_clock_en_o,
  input wire logic [3:0] system_clock_en_o,
  input wire logic chop_clock_off_o,
  input wire logic wake_timer_clock_off_o,
  input wire logic frontend_control_clock_off_o,
  input wire logic [15:0] clock_gate_enables_o,
  input wire logic [2:0] oscillator_control_o
);
  import csg_pkg::*;
  localparam int SETTLE_MAX = 3 * SWITCH_HOLD + 8;
  logic rst_q;
  logic tk;
  logic wr;
  logic open_reg;
  logic [3:0] want_reg;
  assign tk = cyc_i && stb_i && !ack_o;
  assign wr = tk && we_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) open_reg <= 1'b0;
    else if (wr) open_reg <= adr_i == 12'ha0c && dat_i[15:0] == 16'hcb14 && sel_i[1:0] == 2'h3;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) want_reg <= 4'h0;
    else if (wr && adr_i == 12'h414 && sel_i[0]) want_reg <= dat_i[3:0];
  end
  // Reset stretched one cycle so no attempt starts on the edge where reset falls
  always_ff @(posedge clk_i) rst_q <= rst_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || rst_q);
  a_ack_pulse: assert property (tk |=> ack_o ##1 !ack_o)
    else $error("ack not a single pulse");
  a_chop_follow: assert property (
    wr && adr_i == 12'ha70 && sel_i[0] |=> ##1 chop_clock_off_o == $past(dat_i[2], 2))
    else $error("chop gate wrong");
  a_wake_follow: assert property (
    wr && adr_i == 12'ha70 && sel_i[0] |=> ##1 wake_timer_clock_off_o == $past(dat_i[1], 2))
    else $error("wake gate wrong");
  a_fe_follow: assert property (
    wr && adr_i == 12'h410 && sel_i[0] |=> ##1 frontend_control_clock_off_o == $past(dat_i[5], 2))
    else $error("front-end gate wrong");
  a_osc_locked: assert property (
    wr && adr_i == 12'ha10 && !open_reg |=> ##1
    oscillator_control_o == $past(oscillator_control_o, 2))
    else $error("locked osc write landed");
  a_osc_open: assert property (
    wr && adr_i == 12'ha10 && open_reg && sel_i[0] |=> ##1
    oscillator_control_o == $past(dat_i[2:0], 2))
    else $error("unlocked osc write lost");
  a_conv_onehot: assert property (
    converter_clock_en_o == 4'h0 || converter_clock_en_o == 4'(1 << converter_clock_source_o))
    else $error("converter enable mismatch");
  a_sys_onehot: assert property (
    system_clock_en_o == 4'h0 || system_clock_en_o == 4'(1 << system_clock_source_o))
    else $error("system enable mismatch");
  a_switch_dark: assert property (
    !$stable(converter_clock_source_o) |-> converter_clock_en_o == 4'h0 &&
    $past(converter_clock_en_o) == 4'h0)
    else $error("source changed while enabled");
  a_sel_settle: assert property (
    wr && adr_i == 12'h414 && sel_i[0] |-> ##[2:SETTLE_MAX]
    {converter_clock_source_o, system_clock_source_o} == want_reg)
    else $error("selection not applied");
endmodule : csg_clock_ctrl_sva

bind csg_clock_ctrl csg_clock_ctrl_sva #(.SWITCH_HOLD(SWITCH_HOLD)) csg_clock_ctrl_sva_i (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .sel_i(sel_i),
  .dat_i(dat_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .converter_clock_source_o(converter_clock_source_o),
  .system_clock_source_o(system_clock_source_o),
  .converter_clock_en_o(converter_clock_en_o),
  .system_clock_en_o(system_clock_en_o),
  .chop_clock_off_o(chop_clock_off_o),
  .wake_timer_clock_off_o(wake_timer_clock_off_o),
  .frontend_control_clock_off_o(frontend_control_clock_off_o),
  .clock_gate_enables_o(clock_gate_enables_o),
  .oscillator_control_o(oscillator_control_o)
);

/* verification/csg_clock_ctrl_test.sv */
// Purpose: Self-checking bench for csg_clock_ctrl
// Assumes: Switch hold shortened to 1 to keep runs brief
// Notes: Stimulus writes ones to reserved chop bits, breaking the software-side register rules
module csg_clock_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import csg_pkg::*;
  typedef struct {logic [11:0] a; logic [15:0] d; logic [15:0] r; logic [5:0] o;} csg_row_s;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o;
  logic [11:0] adr_i = 12'h000;
  logic [3:0] sel_i = 4'h0, converter_clock_en_o, system_clock_en_o;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic chop_clock_off_o, wake_timer_clock_off_o, frontend_control_clock_off_o;
  csg_src_e converter_clock_source_o, system_clock_source_o;
  logic [15:0] clock_gate_enables_o;
  logic [2:0] oscillator_control_o;
  logic [5:0] outs;
  int error_cnt = 0, checks = 0;
  logic [11:0] rst_a [5] = '{12'h410, 12'h414, 12'ha0c, 12'ha10, 12'ha70};
  logic [15:0] rst_v [5] = '{16'h01c0, 16'h0000, 16'h0000, 16'h0003, 16'h0004};
  // Outputs columns: chop off, wake off, front-end off, oscillator enables
  csg_row_s rows [12] = '{
    '{12'ha70, 16'h0000, 16'h0000, 6'h03}, '{12'ha70, 16'hfff6, 16'h0006, 6'h33},
    '{12'h410, 16'h01e9, 16'h01e9, 6'h3b}, '{12'h410, 16'h01c9, 16'h01c9, 6'h33},
    '{12'ha0c, 16'h1234, 16'h1234, 6'h33}, '{12'ha10, 16'h0004, 16'h0003, 6'h33},
    '{12'ha0c, 16'hcb14, 16'hcb14, 6'h33}, '{12'ha10, 16'h0004, 16'h0004, 6'h34},
    '{12'ha0c, 16'hcb14, 16'hcb14, 6'h34}, '{12'h410, 16'h01c9, 16'h01c9, 6'h34},
    '{12'ha10, 16'h0001, 16'h0004, 6'h34}, '{12'h7fc, 16'hffff, 16'h0000, 6'h34}};
  assign outs = {chop_clock_off_o, wake_timer_clock_off_o, frontend_control_clock_off_o,
    oscillator_control_o};
  always #4 clk_i = ~clk_i;
  csg_clock_ctrl #(.SWITCH_HOLD(1)) csg_clock_ctrl_i (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk
  // Called at a rising edge; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk(n < 20, 1, "bus timeout");
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic close_out();
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
  initial begin
    logic [1:0] c;
    int n;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(outs, 6'h23, "reset gates");
    chk({converter_clock_en_o, system_clock_en_o}, 8'h11, "reset enables");
    chk(clock_gate_enables_o, 16'h01c0, "reset gate copy");
    foreach (rst_a[i]) begin
      wb(0, rst_a[i], 32'h0);
      chk(q, rst_v[i], "reset value");
    end
    foreach (rows[i]) begin
      wb(1, rows[i].a, {16'h0, rows[i].d});
      wb(0, rows[i].a, 32'h0);
      chk(q, rows[i].r, "read back");
      chk(outs, rows[i].o, "gate outputs");
    end
    chk(clock_gate_enables_o, 16'h01c9, "gate copy");
    for (int s = 0; s < 4; s++) begin
      c = 2'(3 - s);
      wb(1, 12'h414, {28'h0, s[1:0], c});
      for (n = 0; n < 40 && {converter_clock_en_o, system_clock_en_o} !==
        {4'(1 << s), 4'(1 << c)}; n++) @(posedge clk_i);
      chk({converter_clock_source_o, system_clock_source_o}, {s[1:0], c}, "sources");
      chk({converter_clock_en_o, system_clock_en_o}, {4'(1 << s), 4'(1 << c)}, "enables");
    end
    wb(1, 12'ha0c, 32'h0000_cb14);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(outs, 6'h23, "second reset");
    chk({converter_clock_en_o, system_clock_en_o}, 8'h11, "second reset");
    chk({converter_clock_source_o, system_clock_source_o}, 4'h0, "second reset sources");
    wb(1, 12'ha10, 32'h0000_0004);
    wb(0, 12'ha10, 32'h0);
    chk(q, 32'h0000_0003, "lock after reset");
    close_out();
  end
endmodule : csg_clock_ctrl_test
